// >>> rtl/tcp_timer.sv
// Purpose: 8-bit timer/counter with prescaler shared with the watchdog, AHB-Lite slave.
// Assumes: hclk is the instruction cycle clock; ext_count_pin is synchronous to hclk.
// Notes:   Interrupt status bit 0 is overflow, bit 1 is prescaler output tick.
// What this block does
// - Clock source select clear: count once per instruction cycle without prescaler.
// - A software write to the count suppresses counting for two cycles.
// - Clock source select set: count on edges of the external pin.
// - Source edge select clear picks rising edge, set picks falling edge.
// - External input is synchronised first; counting follows after a delay.
// - One 8-bit prescaler serves timer or watchdog, never both.
// - Prescaler count has no software read or write access.
// - Assign clear: prescaler feeds timer, ratios 1:2 to 1:256.
// - Assign set: watchdog postscaler, ratios 1:1 to 1:128.
// - Writing the count with timer prescaling clears the prescaler only.
// - Watchdog clear instruction clears the prescaler when assigned to watchdog.
// - Prescaler assignment may change at any time without reset.
// - Rollover from FFh to 00h sets the overflow flag, bit 2.
// - Overflow interrupt on overflow_irq requested only while enable bit 5 is set; irq follows status bit 0 and mask bit 0 regardless.
// - Overflow flag holds until software clears it before re-enabling.
// - Timer stops during sleep, so overflow never wakes the processor.
module tcp_timer #(
	parameter int PRESCALE_WIDTH = 8
) (
	// Clock, reset and enable
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clk_en,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// External count pin and watchdog side
	input  wire logic        ext_count_pin,
	input  wire logic        watchdog_clear_instr,
	input  wire logic        watchdog_tick_in,
	output logic             watchdog_tick_out,
	// Interrupts
	output logic             overflow_irq,
	output logic             irq
);

	// Decodes a byte address into a register index; misaligned or high addresses map nowhere.
	function automatic logic [7:0] addr_index(input logic [31:0] a);
		if (a[1:0] != 2'h0 || a[31:10] != 22'h0)
			return 8'hff;
		return a[9:2];
	endfunction : addr_index

	// Prescale ratio decoded to the low bits of the divider that, all set, mark a completed division.
	function automatic logic [PRESCALE_WIDTH-1:0] ratio_mask(input logic [2:0] r,
	                                                         input logic       wd);
		logic [PRESCALE_WIDTH-1:0] m;
		m = '0;
		if (wd)
			m = PRESCALE_WIDTH'((1 << r) - 1);
		else
			m = PRESCALE_WIDTH'((2 << r) - 1);
		return m;
	endfunction : ratio_mask

	tcp_pkg::tcp_req_t req_reg, req_next;
	logic [7:0]  count_reg, count_next;
	logic [7:0]  intctl_reg, intctl_next;
	logic [7:0]  option_reg, option_next;
	logic [1:0]  status_reg, status_next;
	logic [1:0]  mask_reg, mask_next;
	logic        sleep_reg, sleep_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [PRESCALE_WIDTH-1:0] pre_reg, pre_next;
	logic [1:0]  inhibit_reg, inhibit_next;
	logic        sync1_reg, sync2_reg, sync3_reg;
	logic        wdt_out_reg, wdt_out_next;

	logic        addr_phase;
	logic        wr_count;
	logic        rd_status;
	logic        ext_edge;
	logic        src_event;
	logic        pre_event;
	logic        pre_to_timer;
	logic        pre_done;
	logic        count_step;
	logic        overflow;
	logic [7:0]  wbyte;
	tcp_pkg::tcp_evt_t evt;

	assign addr_phase   = hsel && hready && (htrans == tcp_pkg::HTRANS_NONSEQ ||
	                                        htrans == tcp_pkg::HTRANS_SEQ);
	assign wbyte        = hwdata[7:0];
	assign wr_count     = req_reg.valid && req_reg.write && req_reg.index == tcp_pkg::IDX_TIMER_COUNT;
	assign rd_status    = req_reg.valid && !req_reg.write && req_reg.index == tcp_pkg::IDX_IRQ_STATUS;
	assign pre_to_timer = !option_reg[tcp_pkg::BIT_PRE_ASSIGN];

	// Synchroniser: the first stage feeds only the second.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else if (clk_en) begin
			sync1_reg <= ext_count_pin;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// Edge select: a mux picks the falling or the rising detector on sync3_reg and sync2_reg.
	assign ext_edge = option_reg[tcp_pkg::BIT_EDGE_SEL] ? (sync3_reg && !sync2_reg)
	                                                    : (!sync3_reg && sync2_reg);

	always_comb begin
		src_event = 1'b0;
		if (option_reg[tcp_pkg::BIT_CLK_SRC])
			src_event = ext_edge;
		else
			src_event = 1'b1;
		pre_event = pre_to_timer ? src_event : watchdog_tick_in;
		pre_done  = (pre_reg & ratio_mask(option_reg[2:0], !pre_to_timer))
		            == ratio_mask(option_reg[2:0], !pre_to_timer);
		count_step = 1'b0;
		if (!sleep_reg && inhibit_reg == 2'h0) begin
			if (pre_to_timer)
				count_step = src_event && pre_done;
			else
				count_step = src_event;
		end
		overflow = count_step && count_reg == 8'hff;
		evt.overflow      = overflow;
		evt.prescale_tick = pre_event && pre_done && !pre_to_timer;
		evt.irq           = {evt.prescale_tick, evt.overflow};
	end

	// Main next-state logic.
	always_comb begin
		req_next     = req_reg;
		count_next   = count_reg;
		intctl_next  = intctl_reg;
		option_next  = option_reg;
		status_next  = status_reg;
		mask_next    = mask_reg;
		sleep_next   = sleep_reg;
		pre_next     = pre_reg;
		inhibit_next = inhibit_reg;
		wdt_out_next = 1'b0;
		rdata_next   = rdata_reg;

		req_next.valid = addr_phase;
		req_next.write = hwrite;
		req_next.index = addr_index(haddr);

		if (inhibit_reg != 2'h0)
			inhibit_next = inhibit_reg - 2'h1;
		if (count_step)
			count_next = count_reg + 8'h01;

		// External edges reach the count only after the synchroniser and edge stage.
		// That fixed latency is the whole delay, so no extra counter is kept for it.

		// The prescaler is internal only and has no register window.
		if (pre_event && !(pre_to_timer && (sleep_reg || inhibit_reg != 2'h0)))
			pre_next = pre_done ? '0 : pre_reg + PRESCALE_WIDTH'(1);
		if (!pre_to_timer && pre_event && pre_done)
			wdt_out_next = 1'b1;
		if (!pre_to_timer && watchdog_clear_instr)
			pre_next = '0;

		if (req_reg.valid && req_reg.write) begin
			case (req_reg.index)
				tcp_pkg::IDX_TIMER_COUNT: begin
					count_next   = wbyte;
					inhibit_next = tcp_pkg::WRITE_INHIBIT_CYCLES;
					if (pre_to_timer)
						pre_next = '0;
				end
				tcp_pkg::IDX_INT_CONTROL:   intctl_next = wbyte;
				tcp_pkg::IDX_OPTION_CONFIG: option_next = wbyte;
				tcp_pkg::IDX_IRQ_MASK:      mask_next   = wbyte[1:0];
				tcp_pkg::IDX_CORE_CTRL:     sleep_next  = wbyte[tcp_pkg::BIT_CTRL_SLEEP];
				default: ;
			endcase
		end
		if (rd_status)
			status_next = 2'h0;

		// Set wins over a clear in the same cycle.
		if (overflow)
			intctl_next[tcp_pkg::BIT_OVF_FLAG] = 1'b1;
		status_next = status_next | evt.irq;

		if (addr_phase && !hwrite) begin
			case (addr_index(haddr))
				tcp_pkg::IDX_TIMER_COUNT:   rdata_next = {24'h0, count_next};
				tcp_pkg::IDX_INT_CONTROL:   rdata_next = {24'h0, intctl_next};
				tcp_pkg::IDX_OPTION_CONFIG: rdata_next = {24'h0, option_next};
				tcp_pkg::IDX_IRQ_STATUS:    rdata_next = {30'h0, status_next};
				tcp_pkg::IDX_IRQ_MASK:      rdata_next = {30'h0, mask_next};
				tcp_pkg::IDX_CORE_CTRL:     rdata_next = {31'h0, sleep_next};
				default:                    rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_reg     <= '0;
			count_reg   <= tcp_pkg::COUNT_RESET;
			intctl_reg  <= tcp_pkg::INTCTL_RESET;
			option_reg  <= tcp_pkg::OPTION_RESET;
			status_reg  <= 2'h0;
			mask_reg    <= 2'h0;
			sleep_reg   <= 1'b0;
			pre_reg     <= '0;
			inhibit_reg <= 2'h0;
			wdt_out_reg <= 1'b0;
			rdata_reg   <= 32'h0;
		end else if (clk_en) begin
			req_reg     <= req_next;
			count_reg   <= count_next;
			intctl_reg  <= intctl_next;
			option_reg  <= option_next;
			status_reg  <= status_next;
			mask_reg    <= mask_next;
			sleep_reg   <= sleep_next;
			pre_reg     <= pre_next;
			inhibit_reg <= inhibit_next;
			wdt_out_reg <= wdt_out_next;
			rdata_reg   <= rdata_next;
		end
	end

	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign hrdata            = rdata_reg;
	assign watchdog_tick_out = wdt_out_reg;
	assign overflow_irq      = intctl_reg[tcp_pkg::BIT_OVF_FLAG] &&
	                           intctl_reg[tcp_pkg::BIT_OVF_IRQ_EN];
	assign irq               = |(status_reg & mask_reg);

	// Assertions.
	chk_write_inhibit: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_count |=> !count_step)
		else $error("count advanced right after a count write");
	chk_inhibit_len: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_count |=> inhibit_reg == 2'h2)
		else $error("write inhibit not two cycles");
	chk_timer_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !option_reg[5] && option_reg[3] && !sleep_reg && inhibit_reg == 2'h0
		&& !(req_reg.valid && req_reg.write) |=> count_reg == $past(count_reg) + 8'h01)
		else $error("timer mode failed to step");
	chk_ovf_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && overflow && !wr_count |=> intctl_reg[2] && count_reg == 8'h00)
		else $error("overflow flag not set on rollover");
	chk_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
		!intctl_reg[5] |-> !overflow_irq)
		else $error("overflow interrupt while disabled");
	chk_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && intctl_reg[2] && !(req_reg.valid && req_reg.write) |=> intctl_reg[2])
		else $error("overflow flag dropped without a write");
	chk_sleep_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
		sleep_reg |-> !count_step)
		else $error("count moved during sleep");
	chk_prescale_clr: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_count && pre_to_timer |=> pre_reg == '0 && $stable(option_reg))
		else $error("prescaler not cleared by count write");
	chk_wd_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !pre_to_timer && watchdog_clear_instr && !(req_reg.valid && req_reg.write)
		|=> pre_reg == '0)
		else $error("watchdog clear left prescaler set");
	chk_wd_owner: assert property (@(posedge hclk) disable iff (!hresetn)
		watchdog_tick_out |-> $past(option_reg[3]))
		else $error("watchdog tick while prescaler on timer");
	chk_ext_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && option_reg[5] && !ext_edge |-> !count_step)
		else $error("counter mode stepped without an edge");


	// A sleeping timer must not let its prescaler creep either.
	chk_sleep_pre: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && sleep_reg && pre_to_timer && !wr_count |=> $stable(pre_reg))
		else $error("prescaler moved during sleep");

	// A completed watchdog division gives one tick one cycle later.
	chk_wd_tick_out: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && !pre_to_timer && watchdog_tick_in && pre_done |=> watchdog_tick_out)
		else $error("watchdog postscaler tick missing");

	// While the timer owns the prescaler the watchdog gets no postscaled tick.
	chk_timer_no_wd: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && pre_to_timer |=> !watchdog_tick_out)
		else $error("watchdog tick while timer owns prescaler");

	// Without a source event the timer prescaler holds its count.
	chk_pre_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && pre_to_timer && !src_event && !wr_count |=> $stable(pre_reg))
		else $error("prescaler moved without an event");

	// A prescaled step only happens on a completed division.
	chk_step_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && pre_to_timer && count_step |->
		(pre_reg & ratio_mask(option_reg[2:0], 1'b0)) == ratio_mask(option_reg[2:0], 1'b0))
		else $error("prescaled step before division complete");

	// Every rollover is also recorded in the interrupt status.
	chk_ovf_status: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && overflow |=> status_reg[0])
		else $error("overflow not recorded in status");

	// A status read clears everything except events of that very cycle.
	chk_status_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && rd_status |=> status_reg == $past(evt.irq))
		else $error("status read did not clear");

	// Flag and enable both set must raise the overflow request.
	chk_ovf_irq_on: assert property (@(posedge hclk) disable iff (!hresetn)
		intctl_reg[2] && intctl_reg[5] |-> overflow_irq)
		else $error("overflow interrupt missing");

	// A synchronised rising edge steps an unprescaled counter.
	chk_rise_count: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && option_reg[5] && !option_reg[4] && !pre_to_timer && !sleep_reg
		&& inhibit_reg == 2'h0 && !sync3_reg && sync2_reg |-> count_step)
		else $error("rising edge not counted");

	// With the edge select set only falling edges count.
	chk_fall_count: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && option_reg[5] && option_reg[4] && !pre_to_timer && !sleep_reg
		&& inhibit_reg == 2'h0 && sync3_reg && !sync2_reg |-> count_step)
		else $error("falling edge not counted");

	// The write inhibit also holds the timer prescaler.
	chk_inhibit_pre: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && pre_to_timer && inhibit_reg != 2'h0 && !wr_count |=> $stable(pre_reg))
		else $error("prescaler moved during write inhibit");

	// Unmapped reads, the prescaler among them, return zero.
	chk_unmapped_read: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && addr_phase && !hwrite && addr_index(haddr) == 8'hff |=> hrdata == 32'h0)
		else $error("unmapped read returned data");

	// A count write lands as written.
	chk_count_write: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && wr_count |=> count_reg == $past(wbyte))
		else $error("count write lost");

	// The option register may be rewritten at any time.
	chk_option_write: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en && req_reg.valid && req_reg.write && req_reg.index == tcp_pkg::IDX_OPTION_CONFIG
		|=> option_reg == $past(wbyte))
		else $error("option write lost");

	// Covers for the main scenarios.
	cov_overflow:  cover property (@(posedge hclk) disable iff (!hresetn) overflow);
	cov_pre_step:  cover property (@(posedge hclk) disable iff (!hresetn)
		pre_to_timer && count_step);
	cov_ext_count: cover property (@(posedge hclk) disable iff (!hresetn)
		option_reg[5] && count_step);
	cov_wd_tick:   cover property (@(posedge hclk) disable iff (!hresetn) watchdog_tick_out);
	cov_irq:       cover property (@(posedge hclk) disable iff (!hresetn) overflow_irq);
endmodule : tcp_timer

// >>> rtl/tcp_pkg.sv
// Purpose: Shared constants and types for the 8-bit timer/counter block.
// Assumes: AHB-Lite register access, one word per register.
// Notes:   Printed offsets are not all multiples of four, so each is an index.
package tcp_pkg;
	localparam logic [7:0] IDX_TIMER_COUNT   = 8'h01;
	localparam logic [7:0] IDX_INT_CONTROL   = 8'h0b;
	localparam logic [7:0] IDX_OPTION_CONFIG = 8'h81;
	localparam logic [7:0] IDX_IRQ_STATUS    = 8'h90;
	localparam logic [7:0] IDX_IRQ_MASK      = 8'h91;
	localparam logic [7:0] IDX_CORE_CTRL     = 8'h92;

	localparam logic [7:0] OPTION_RESET      = 8'hff;
	localparam logic [7:0] INTCTL_RESET      = 8'h00;
	localparam logic [7:0] COUNT_RESET       = 8'h00;

	localparam int BIT_CLK_SRC     = 5;
	localparam int BIT_EDGE_SEL    = 4;
	localparam int BIT_PRE_ASSIGN  = 3;
	localparam int BIT_OVF_FLAG    = 2;
	localparam int BIT_OVF_IRQ_EN  = 5;

	localparam int BIT_CTRL_SLEEP  = 0;
	localparam int BIT_CTRL_WDCLR  = 1;

	localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
	localparam logic [1:0] EXT_SYNC_DELAY       = 2'h2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] index;
	} tcp_req_t;

	typedef struct packed {
		logic [1:0] irq;
		logic       overflow;
		logic       prescale_tick;
	} tcp_evt_t;
endpackage : tcp_pkg

// >>> sim/tcp_pin_src.sv
// Purpose: Source of count edges for the external count pin.
// Assumes: The pin changes by non-blocking assignment right after a rising hclk edge.
// Notes:   The pin keeps its level between bursts, as a real input would.
module tcp_pin_src (
	// Clock and pin
	input  wire logic hclk,
	output logic      ext_count_pin
);
	initial ext_count_pin = 1'b0;

	// Each level stands for hold cycles, so a slow source is as easy as a prompt one.
	task automatic edges(input int n, input int hold);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			ext_count_pin <= ~ext_count_pin;
			repeat (hold - 1) @(posedge hclk);
		end
	endtask : edges
endmodule : tcp_pin_src

// >>> sim/tcp_timer_test.sv
// Purpose: Self-checking bench for the timer/counter over AHB-Lite.
// Assumes: Zero wait states are not assumed; every wait follows hreadyout.
// Notes:   Pin and watchdog ticks come from the bench; clk_en and hsize are tied.
`define TCP_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tcp_timer_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        hclk, hresetn, hsel, hwrite, tick_in, wd_clr;
	logic        hreadyout, hresp, tick_out, ovf_irq, irq, pin;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rdata;
	int          n_errors = 0, n_compared = 0, n_ticks = 0, t0;

	tcp_timer #(.PRESCALE_WIDTH(8)) tcp_timer_i (.hclk(hclk), .hresetn(hresetn),
		.clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(pin),
		.watchdog_clear_instr(wd_clr), .watchdog_tick_in(tick_in),
		.watchdog_tick_out(tick_out), .overflow_irq(ovf_irq), .irq(irq));
	tcp_pin_src tcp_pin_src_i (.hclk(hclk), .ext_count_pin(pin));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) if (tick_out === 1'b1) n_ticks++;

	task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= tcp_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdata = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(idx, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		bus(idx, 1'b0, 8'h00);
		`TCP_CHK(rdata, {24'h0, exp})
	endtask : rd

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge hclk);
			tick_in <= 1'b1;
			@(posedge hclk);
			tick_in <= 1'b0;
		end
	endtask : ticks

	task automatic wd_clear();
		@(posedge hclk);
		wd_clr <= 1'b1;
		@(posedge hclk);
		wd_clr <= 1'b0;
	endtask : wd_clear

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	// The longest prescaler ratios dominate the run; the limit leaves ample margin.
	initial begin
		#500000;
		n_errors++;
		final_report();
	end

	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, tick_in, wd_clr, htrans, haddr, hwdata} = '0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(tcp_pkg::IDX_OPTION_CONFIG, 8'hff);
		rd(tcp_pkg::IDX_INT_CONTROL, 8'h00);
		rd(tcp_pkg::IDX_TIMER_COUNT, 8'h00);
		rd(tcp_pkg::IDX_IRQ_STATUS, 8'h00);
		rd(8'h50, 8'h00);
		`TCP_CHK(hresp, 1'b0)
		for (int ps = 0; ps < 8; ps++) begin
			wr(tcp_pkg::IDX_OPTION_CONFIG, 8'h28 | 8'(ps));
			wd_clear();
			ticks((1 << ps) - 1);
			wd_clear();
			t0 = n_ticks;
			ticks((2 << ps) - 1);
			repeat (3) @(posedge hclk);
			`TCP_CHK(n_ticks - t0, 1)
		end
		rd(tcp_pkg::IDX_OPTION_CONFIG, 8'h2f);
		rd(tcp_pkg::IDX_IRQ_STATUS, 8'h02);
		wr(tcp_pkg::IDX_OPTION_CONFIG, 8'h28);
		wr(tcp_pkg::IDX_TIMER_COUNT, 8'h00);
		tcp_pin_src_i.edges(3, 4);
		repeat (6) @(posedge hclk);
		rd(tcp_pkg::IDX_TIMER_COUNT, 8'h02);
		wr(tcp_pkg::IDX_OPTION_CONFIG, 8'h38);
		wr(tcp_pkg::IDX_TIMER_COUNT, 8'h00);
		tcp_pin_src_i.edges(1, 4);
		repeat (6) @(posedge hclk);
		rd(tcp_pkg::IDX_TIMER_COUNT, 8'h01);
		for (int ps = 0; ps < 8; ps++) begin
			wr(tcp_pkg::IDX_OPTION_CONFIG, 8'h20 | 8'(ps));
			tcp_pin_src_i.edges(2 * ((2 << ps) - 1), 2);
			repeat (6) @(posedge hclk);
			wr(tcp_pkg::IDX_TIMER_COUNT, 8'h00);
			tcp_pin_src_i.edges(2 * ((4 << ps) - 1), 2);
			repeat (6) @(posedge hclk);
			rd(tcp_pkg::IDX_TIMER_COUNT, 8'h01);
		end
		wd_clear();
		wr(tcp_pkg::IDX_OPTION_CONFIG, 8'h08);
		wr(tcp_pkg::IDX_TIMER_COUNT, 8'h10);
		rd(tcp_pkg::IDX_TIMER_COUNT, 8'h10);
		rd(tcp_pkg::IDX_TIMER_COUNT, 8'h11);
		rd(tcp_pkg::IDX_TIMER_COUNT, 8'h13);
		wr(tcp_pkg::IDX_INT_CONTROL, 8'h20);
		wr(tcp_pkg::IDX_TIMER_COUNT, 8'hfe);
		repeat (10) @(posedge hclk);
		#1;
		`TCP_CHK(ovf_irq, 1'b1)
		`TCP_CHK(irq, 1'b0)
		rd(tcp_pkg::IDX_INT_CONTROL, 8'h24);
		wr(tcp_pkg::IDX_IRQ_MASK, 8'h01);
		#1;
		`TCP_CHK(irq, 1'b1)
		rd(tcp_pkg::IDX_IRQ_STATUS, 8'h01);
		rd(tcp_pkg::IDX_IRQ_STATUS, 8'h00);
		#1;
		`TCP_CHK(irq, 1'b0)
		wr(tcp_pkg::IDX_INT_CONTROL, 8'h04);
		#1;
		`TCP_CHK(ovf_irq, 1'b0)
		rd(tcp_pkg::IDX_INT_CONTROL, 8'h04);
		// Software clears the flag before it enables the interrupt again.
		wr(tcp_pkg::IDX_INT_CONTROL, 8'h00);
		wr(tcp_pkg::IDX_INT_CONTROL, 8'h20);
		#1;
		`TCP_CHK(ovf_irq, 1'b0)
		wr(tcp_pkg::IDX_CORE_CTRL, 8'h01);
		wr(tcp_pkg::IDX_TIMER_COUNT, 8'h40);
		repeat (20) @(posedge hclk);
		rd(tcp_pkg::IDX_TIMER_COUNT, 8'h40);
		final_report();
	end
endmodule : tcp_timer_test
